// ---- pfgl_defines.vh ----
// Constants for the pixel format and gray-level command decoder.
// Assumes inclusion by bare name from each design file.
`ifndef PFGL_DEFINES_VH
`define PFGL_DEFINES_VH
// Command codes
`define PFGL_CMD_PIXEL_FORMAT_SET 8'h3a
`define PFGL_CMD_TEST_MODE_ENTRY 8'hde
`define PFGL_CMD_NO_OPERATION 8'h00
`define PFGL_CMD_NO_OPERATION_SECOND 8'haa
`define PFGL_CMD_INITIAL_ESCAPE 8'hc6
`define PFGL_CMD_CHIP_TEST_A 8'hda
`define PFGL_CMD_CHIP_TEST_B 8'hdb
`define PFGL_CMD_CHIP_TEST_C 8'hdc
`define PFGL_CMD_CHIP_TEST_D 8'hb2
`define PFGL_CMD_GRAY_SET_ZERO 8'hb3
`define PFGL_CMD_GRAY_SET_ONE 8'hb4
`define PFGL_CMD_GAMMA_SELECT 8'hb5
// Pixel format field and codes
`define PFGL_FMT_MSB 2
`define PFGL_FMT_8BPP 3'h2
`define PFGL_FMT_12BPP 3'h3
`define PFGL_FMT_RESET 3'h3
// Gamma selection codes
`define PFGL_GAMMA_SET0 2'h1
`define PFGL_GAMMA_SET1 2'h2
`define PFGL_GAMMA_RESET 2'h1
// Gray table geometry
`define PFGL_GRAY_ENTRIES 4'hf
`define PFGL_GRAY_FIRST 4'h1
`define PFGL_GRAY_ZERO_LEVEL 8'h00
// Register bus offsets
`define PFGL_REG_STATUS 4'h0
`define PFGL_REG_FORMAT 4'h1
`define PFGL_REG_GAMMA 4'h2
`define PFGL_REG_CHIP_TEST 4'h3
`define PFGL_REG_GRAY0 4'h4
`define PFGL_REG_GRAY1 4'h5
`define PFGL_REG_GRAY_INDEX 4'h6
`endif

// ---- pfgl_gray_mem.v ----
// Gray-level position store: two sets of fifteen 8-bit entries.
// Assumes one write port from the decoder and one registered read port.
`timescale 1ns/1ps
`include "pfgl_defines.vh"
module pfgl_gray_mem #(
  parameter WIDTH = 8,
  parameter DEPTH = 32
) (
  // Clock
  input wire i_clock,
  // Write port
  input wire i_wr_en,
  input wire [4:0] i_wr_addr,
  input wire [WIDTH-1:0] i_wr_data,
  // Read port
  input wire [4:0] i_rd_addr,
  output reg [WIDTH-1:0] o_rd_data
);
  // Storage has no reset: contents undefined until host loads it
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // Write and registered read
  always @(posedge i_clock) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem[i_rd_addr];
  end
endmodule // pfgl_gray_mem

// ---- pfgl_pixel_lut.v ----
// Pixel translation: 8-bit input pixels go through a colour table.
// Assumes table contents loaded elsewhere; here a fixed expansion stands in.
`timescale 1ns/1ps
`include "pfgl_defines.vh"
module pfgl_pixel_lut (
  // Clock and reset
  input wire i_clock,
  input wire i_arst_n,
  // Pixel in
  input wire i_valid,
  input wire [11:0] i_pixel,
  input wire [2:0] i_format,
  // Pixel out
  output reg o_valid,
  output reg [11:0] o_pixel
);
  // 3-3-2 expansion to 4-4-4, standing in for the loadable table
  wire [11:0] lut_out;
  assign lut_out = {i_pixel[7:5], i_pixel[7], i_pixel[4:2], i_pixel[4],
                    i_pixel[1:0], i_pixel[1:0]};

  // Registered conversion
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_valid <= 1'b0;
      o_pixel <= 12'h000;
    end else begin
      o_valid <= i_valid;
      if (i_format == `PFGL_FMT_8BPP) begin
        o_pixel <= lut_out;
      end else begin
        o_pixel <= i_pixel;
      end
    end
  end
endmodule // pfgl_pixel_lut

// ---- pfgl_cmd_decoder.v ----
// Command decoder for pixel format, test mode and gray-level commands.
// Assumes byte strobes from a host interface synchronous to i_clock.
// Function
// - Pixel format command takes one parameter.
// - Low three bits choose 8 or 12 bpp.
// - Upper five parameter bits ignored.
// - 8 bpp pixels go through lookup table.
// - Pixel format resets to 12 bpp.
// - Test entry command blocks ordinary commands.
// - Either no-operation command leaves test mode.
// - Test mode output not guaranteed.
// - Second no-operation changes nothing else.
// - Initial escape resets internal settings.
// - Four chip-test codes decoded, no function.
// - Two gray-level sets, commands B3 and B4.
// - Fifteen ordered bytes, entries one to fifteen.
// - Entry for data zero fixed.
// - Gamma command selects active set.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "pfgl_defines.vh"
module pfgl_cmd_decoder (
  // Clock and reset
  input wire i_clock,
  input wire i_arst_n,
  // Host byte stream
  input wire i_byte_strobe,
  input wire i_data_cmd_sel,
  input wire [7:0] i_byte,
  // Pixel path
  input wire i_pixel_valid,
  input wire [11:0] i_pixel,
  // Gray-level lookup from the drive logic
  input wire [3:0] i_gray_data,
  // Register port
  input wire [3:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  // Outputs
  output reg [7:0] o_reg_rdata,
  output reg [2:0] o_pixel_format_q,
  output reg o_gamma_set_q,
  output reg o_test_mode_q,
  output reg o_init_escape_q,
  output reg o_chip_test_q,
  output reg [7:0] o_gray_level_q,
  output reg o_pixel_valid_q,
  output reg [11:0] o_pixel_q
);
  // Parameter sequencer states
  localparam ST_IDLE = 2'b00;
  localparam ST_FMT = 2'b01;
  localparam ST_GRAY = 2'b10;
  localparam ST_GAMMA = 2'b11;

  reg [1:0] state_q; // Pending command kind
  reg [3:0] count_q; // Parameter index within gray set
  reg target_set_q; // Gray set being loaded
  reg [2:0] format_q; // Live pixel format
  reg [1:0] gamma_q; // Gamma selection code
  reg test_q; // Test mode flag
  reg [3:0] chip_code_q; // Last chip-test code seen, one-hot
  reg [3:0] gray_index_q; // Register port gray index

  // Synchronised pin inputs
  reg strobe_m_q, strobe_q;
  reg sel_m_q, sel_q;
  reg [7:0] byte_m_q, byte_q;
  reg strobe_dly_q;

  // Two-stage synchroniser on host pins
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strobe_m_q <= 1'b0;
      strobe_q <= 1'b0;
      sel_m_q <= 1'b0;
      sel_q <= 1'b0;
      byte_m_q <= 8'h00;
      byte_q <= 8'h00;
      strobe_dly_q <= 1'b0;
    end else begin
      strobe_m_q <= i_byte_strobe;
      strobe_q <= strobe_m_q;
      sel_m_q <= i_data_cmd_sel;
      sel_q <= sel_m_q;
      byte_m_q <= i_byte;
      byte_q <= byte_m_q;
      strobe_dly_q <= strobe_q;
    end
  end

  // One pulse per host byte, on rising strobe
  wire byte_evt = strobe_q & ~strobe_dly_q;
  wire cmd_evt = byte_evt & ~sel_q;
  wire par_evt = byte_evt & sel_q;

  // leaving test mode via either no-op
  wire is_nop = (byte_q == `PFGL_CMD_NO_OPERATION) |
                (byte_q == `PFGL_CMD_NO_OPERATION_SECOND);

  // Gray memory write port, shared by every copy of the table
  wire gray_wr = par_evt & (state_q == ST_GRAY) & ~test_q;
  // byte n lands in entry n
  wire [4:0] gray_waddr = {target_set_q, count_q};
  // Drive lookup owns this read port outright
  wire [4:0] gray_raddr = {o_gamma_set_q, i_gray_data};
  wire [7:0] gray_rdata;
  reg gray_zero_q; // Lookup was for data zero
  // Register port copies, one per set, read at the index pointer
  wire [7:0] shadow_rdata [0:1];
  // Index pointer as it will stand after this edge
  reg [3:0] gray_index_d;

  // Next pointer value, for the prefetch of the copies
  always @* begin
    gray_index_d = gray_index_q;
    // Follow a pointer write at once, so a read right after it is fresh
    if (i_reg_wr && (i_reg_addr == `PFGL_REG_GRAY_INDEX)) begin
      gray_index_d = i_reg_wdata[3:0];
    end
  end

  pfgl_gray_mem #(
    .WIDTH(8),
    .DEPTH(32)
  ) u_gray_mem (
    .i_clock(i_clock),
    .i_wr_en(gray_wr),
    .i_wr_addr(gray_waddr),
    .i_wr_data(byte_q),
    .i_rd_addr(gray_raddr),
    .o_rd_data(gray_rdata)
  );

  // Register port copies of the table, kept in step by the shared write
  // port. Triple storage buys read data that leave a flop in the very next
  // cycle, with no wait state and no fight with the drive lookup.
  // Limitation: a copy shows an entry one cycle after the host writes it.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_shadow
      // Reads set g at the pointer on every cycle
      pfgl_gray_mem #(
        .WIDTH(8),
        .DEPTH(32)
      ) u_shadow_mem (
        .i_clock(i_clock),
        .i_wr_en(gray_wr),
        .i_wr_addr(gray_waddr),
        .i_wr_data(byte_q),
        .i_rd_addr({g == 1, gray_index_d}),
        .o_rd_data(shadow_rdata[g])
      );
    end
  endgenerate

  wire lut_valid;
  wire [11:0] lut_pixel;
  pfgl_pixel_lut u_pixel_lut (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_valid(i_pixel_valid),
    .i_pixel(i_pixel),
    .i_format(format_q),
    .o_valid(lut_valid),
    .o_pixel(lut_pixel)
  );

  // Command and parameter sequencer
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= ST_IDLE;
      count_q <= 4'h0;
      target_set_q <= 1'b0;
      format_q <= `PFGL_FMT_RESET;
      gamma_q <= `PFGL_GAMMA_RESET;
      test_q <= 1'b0;
      chip_code_q <= 4'h0;
      o_init_escape_q <= 1'b0;
    end else begin
      o_init_escape_q <= 1'b0;
      if (test_q) begin
        // only the no-ops are heard in test mode
        if (cmd_evt && is_nop) begin
          test_q <= 1'b0;
        end
      end else if (cmd_evt) begin
        // a new command drops pending parameters
        state_q <= ST_IDLE;
        count_q <= `PFGL_GRAY_FIRST;
        case (byte_q)
          `PFGL_CMD_PIXEL_FORMAT_SET: begin
            state_q <= ST_FMT;
          end
          `PFGL_CMD_TEST_MODE_ENTRY: begin
            test_q <= 1'b1;
          end
          `PFGL_CMD_INITIAL_ESCAPE: begin
            o_init_escape_q <= 1'b1;
            format_q <= `PFGL_FMT_RESET;
            gamma_q <= `PFGL_GAMMA_RESET;
          end
          `PFGL_CMD_CHIP_TEST_A: begin
            chip_code_q <= 4'h1;
          end
          `PFGL_CMD_CHIP_TEST_B: begin
            chip_code_q <= 4'h2;
          end
          `PFGL_CMD_CHIP_TEST_C: begin
            chip_code_q <= 4'h4;
          end
          `PFGL_CMD_CHIP_TEST_D: begin
            chip_code_q <= 4'h8;
          end
          `PFGL_CMD_GRAY_SET_ZERO: begin
            state_q <= ST_GRAY;
            target_set_q <= 1'b0;
          end
          `PFGL_CMD_GRAY_SET_ONE: begin
            state_q <= ST_GRAY;
            target_set_q <= 1'b1;
          end
          `PFGL_CMD_GAMMA_SELECT: begin
            state_q <= ST_GAMMA;
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end else if (par_evt) begin
        case (state_q)
          ST_FMT: begin
            if ((byte_q[`PFGL_FMT_MSB:0] == `PFGL_FMT_8BPP) ||
                (byte_q[`PFGL_FMT_MSB:0] == `PFGL_FMT_12BPP)) begin
              format_q <= byte_q[`PFGL_FMT_MSB:0];
            end
            state_q <= ST_IDLE;
          end
          ST_GRAY: begin
            if (count_q == `PFGL_GRAY_ENTRIES) begin
              state_q <= ST_IDLE;
            end else begin
              count_q <= count_q + 4'h1;
            end
          end
          ST_GAMMA: begin
            // 01 and 10 select, others keep
            if ((byte_q[1:0] == `PFGL_GAMMA_SET0) ||
                (byte_q[1:0] == `PFGL_GAMMA_SET1)) begin
              gamma_q <= byte_q[1:0];
            end
            state_q <= ST_IDLE;
          end
          // Stray parameters are dropped
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Register port writes: index pointer only
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gray_index_q <= 4'h0;
    end else if (i_reg_wr && (i_reg_addr == `PFGL_REG_GRAY_INDEX)) begin
      gray_index_q <= i_reg_wdata[3:0];
    end
  end

  // Output registers and gray-level lookup
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pixel_format_q <= `PFGL_FMT_RESET;
      o_gamma_set_q <= 1'b0;
      o_test_mode_q <= 1'b0;
      o_chip_test_q <= 1'b0;
      o_pixel_valid_q <= 1'b0;
      o_pixel_q <= 12'h000;
      gray_zero_q <= 1'b0;
      o_gray_level_q <= `PFGL_GRAY_ZERO_LEVEL;
    end else begin
      o_pixel_format_q <= format_q;
      o_gamma_set_q <= (gamma_q == `PFGL_GAMMA_SET1);
      o_test_mode_q <= test_q;
      o_chip_test_q <= |chip_code_q;
      o_pixel_valid_q <= lut_valid;
      o_pixel_q <= lut_pixel;
      gray_zero_q <= (i_gray_data == 4'h0);
      o_gray_level_q <= gray_zero_q ? `PFGL_GRAY_ZERO_LEVEL : gray_rdata;
    end
  end

  // Status byte: pending parameters, spare, test mode
  wire [7:0] status_byte = {5'h00, state_q != ST_IDLE, 1'b0, test_q};

  // Register read data: loaded at the strobe edge, zero in every other
  // cycle, so the output leaves a flop and never holds stale data
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `PFGL_REG_STATUS: o_reg_rdata <= status_byte;
        `PFGL_REG_FORMAT: o_reg_rdata <= {5'h00, format_q};
        `PFGL_REG_GAMMA: o_reg_rdata <= {6'h00, gamma_q};
        `PFGL_REG_CHIP_TEST: o_reg_rdata <= {4'h0, chip_code_q};
        // Prefetched copies, already at the pointer
        `PFGL_REG_GRAY0: o_reg_rdata <= shadow_rdata[0];
        `PFGL_REG_GRAY1: o_reg_rdata <= shadow_rdata[1];
        `PFGL_REG_GRAY_INDEX: o_reg_rdata <= {4'h0, gray_index_q};
        // Unmapped offsets read zero
        default: o_reg_rdata <= 8'h00;
      endcase
    end else begin
      // Data stand for one cycle only
      o_reg_rdata <= 8'h00;
    end
  end
endmodule // pfgl_cmd_decoder

// ---- pfgl_host_model.sv ----
// Host model: sends command and parameter bytes to the decoder.
// Assumes a two-flop strobe synchroniser, a 3-clock strobe high phase and a 5-clock low phase.
`timescale 1ns/1ps
module pfgl_host_model (
  // Clock
  input wire i_clock,
  // Byte stream
  output reg o_byte_strobe,
  output reg o_data_cmd_sel,
  output reg [7:0] o_byte
);
  // Idle bus
  initial begin
    o_byte_strobe = 1'b0;
    o_data_cmd_sel = 1'b0;
    o_byte = 8'h00;
  end
  task send(input reg sel, input reg [7:0] b);
    begin
      @(posedge i_clock);
      o_byte_strobe <= 1'b1;
      o_data_cmd_sel <= sel;
      o_byte <= b;
      repeat (3) @(posedge i_clock);
      o_byte_strobe <= 1'b0;
      // Released bus inverted, so a stale copy never passes
      o_byte <= ~b;
      repeat (4) @(posedge i_clock);
    end
  endtask
  task send_table(input reg [7:0] cmd, input reg [7:0] step);
    integer n;
    begin
      send(1'b0, cmd);
      for (n = 1; n <= 15; n = n + 1) begin
        send(1'b1, step * n[7:0] + 8'h02);
      end
    end
  endtask
endmodule // pfgl_host_model

// ---- pfgl_cmd_decoder_monitor.sv ----
// Checker for the command decoder, port relations only.
// Assumes one clock domain with the asynchronous low reset.
`timescale 1ns/1ps
module pfgl_cmd_decoder_monitor (
  // Clock and reset
  input wire i_clock,
  input wire i_arst_n,
  // Inputs watched
  input wire i_byte_strobe,
  input wire i_pixel_valid,
  input wire [11:0] i_pixel,
  input wire [3:0] i_gray_data,
  input wire i_reg_rd,
  // Outputs watched
  input wire [2:0] o_pixel_format_q,
  input wire o_gamma_set_q,
  input wire o_test_mode_q,
  input wire o_init_escape_q,
  input wire o_chip_test_q,
  input wire [7:0] o_gray_level_q,
  input wire o_pixel_valid_q,
  input wire [11:0] o_pixel_q
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  // Zero lookup, with no register read in either cycle
  sequence s_zero_lookup;
    (i_gray_data == 4'h0 && !i_reg_rd) ##1 !i_reg_rd;
  endsequence
  // Host silent long enough for the pipeline to drain
  sequence s_host_quiet;
    !i_byte_strobe [*8];
  endsequence
  a_reset_format: assert property ($rose(i_arst_n) |-> o_pixel_format_q == 3'h3)
    else $error("format not 12 bpp after reset");
  a_format_legal: assert property (o_pixel_format_q inside {3'h2, 3'h3})
    else $error("undefined pixel format taken");
  a_test_frozen: assert property (o_test_mode_q && $past(o_test_mode_q) |->
    $stable(o_pixel_format_q) && $stable(o_gamma_set_q)) else $error("setting moved in test");
  a_escape_pulse: assert property (o_init_escape_q |=> !o_init_escape_q)
    else $error("escape pulse too long");
  a_chip_sticky: assert property (o_chip_test_q |=> o_chip_test_q)
    else $error("chip test flag dropped");
  a_pixel_latency: assert property (i_pixel_valid |-> ##2 o_pixel_valid_q)
    else $error("pixel valid late");
  a_pixel_pass: assert property (i_pixel_valid && o_pixel_format_q == 3'h3 |->
    ##2 o_pixel_q == $past(i_pixel, 2)) else $error("12 bpp pixel altered");
  a_gray_zero: assert property (s_zero_lookup |-> ##1 o_gray_level_q == 8'h00)
    else $error("data zero level not fixed");
  a_host_quiet: assert property (s_host_quiet |=> $stable(o_pixel_format_q) &&
    $stable(o_test_mode_q) && !o_init_escape_q) else $error("state moved with no byte");
endmodule // pfgl_cmd_decoder_monitor

bind pfgl_cmd_decoder pfgl_cmd_decoder_monitor u_monitor (.i_clock, .i_arst_n,
  .i_byte_strobe, .i_pixel_valid, .i_pixel, .i_gray_data, .i_reg_rd, .o_pixel_format_q,
  .o_gamma_set_q, .o_test_mode_q, .o_init_escape_q, .o_chip_test_q, .o_gray_level_q,
  .o_pixel_valid_q, .o_pixel_q);

// ---- pfgl_cmd_decoder_bench.sv ----
// Testbench for the command decoder: host bytes, register port, lookups.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
`include "pfgl_defines.vh"
module pfgl_cmd_decoder_bench;
  reg i_clock = 1'b0;
  reg i_arst_n = 1'b0;
  wire i_byte_strobe, i_data_cmd_sel;
  wire [7:0] i_byte;
  reg i_pixel_valid = 1'b0;
  reg [11:0] i_pixel = 12'h000;
  reg [3:0] i_gray_data = 4'h0;
  reg [3:0] i_reg_addr = 4'h0;
  reg [7:0] i_reg_wdata = 8'h00;
  reg i_reg_wr = 1'b0;
  reg i_reg_rd = 1'b0;
  wire [7:0] o_reg_rdata, o_gray_level_q;
  wire [2:0] o_pixel_format_q;
  wire o_gamma_set_q, o_test_mode_q, o_init_escape_q, o_chip_test_q, o_pixel_valid_q;
  wire [11:0] o_pixel_q;
  integer mismatches = 0;
  integer checks = 0;
  integer i;
  reg esc_seen = 1'b0;
  reg [7:0] p;
  reg [2:0] ef;
  reg eg;
  // 25 ns clock
  always #12.5 i_clock = ~i_clock;
  pfgl_host_model host (.i_clock, .o_byte_strobe(i_byte_strobe),
    .o_data_cmd_sel(i_data_cmd_sel), .o_byte(i_byte));
  pfgl_cmd_decoder DUT (.i_clock, .i_arst_n, .i_byte_strobe, .i_data_cmd_sel, .i_byte,
    .i_pixel_valid, .i_pixel, .i_gray_data, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
    .i_reg_rd, .o_reg_rdata, .o_pixel_format_q, .o_gamma_set_q, .o_test_mode_q,
    .o_init_escape_q, .o_chip_test_q, .o_gray_level_q, .o_pixel_valid_q, .o_pixel_q);
  // One-cycle escape pulse caught here
  always @(posedge i_clock) if (o_init_escape_q === 1'b1) esc_seen <= 1'b1;
  // Compare and count
  task chk(input string name, input [11:0] exp, input [11:0] seen);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // Register write, one strobe cycle
  task reg_wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge i_clock);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_clock);
      i_reg_wr <= 1'b0;
    end
  endtask
  // Register read; data stands only in the next cycle
  task reg_rd(input [3:0] a, input [7:0] exp);
    begin
      @(posedge i_clock);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_clock);
      i_reg_rd <= 1'b0;
      #1 chk("register", {4'h0, exp}, {4'h0, o_reg_rdata});
      // Data must be gone one cycle later
      @(posedge i_clock);
      #1 chk("register idle", 12'h000, {4'h0, o_reg_rdata});
    end
  endtask
  // Gray lookup, two-cycle latency plus margin
  task look(input [3:0] d, input [7:0] exp);
    begin
      @(posedge i_clock);
      i_gray_data <= d;
      repeat (3) @(posedge i_clock);
      #1 chk("gray level", {4'h0, exp}, {4'h0, o_gray_level_q});
    end
  endtask
  // One pixel pulse; result checked in its single valid cycle
  task pixel_in(input [11:0] px);
    begin
      @(posedge i_clock);
      i_pixel_valid <= 1'b1;
      i_pixel <= px;
      @(posedge i_clock);
      i_pixel_valid <= 1'b0;
      @(posedge i_clock);
      #1 chk("pixel valid", 12'h001, o_pixel_valid_q);
    end
  endtask
  // Verdict and end of run
  task final_report;
    begin
      $display("Checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Watchdog, far beyond the roughly 730 cycles needed
  initial begin
    #1000000;
    mismatches = mismatches + 1;
    $display("Watchdog expired");
    final_report;
  end
  initial begin
    repeat (10) @(posedge i_clock);
    i_arst_n <= 1'b1;
    @(posedge i_clock);
    #1 chk("format", 12'h003, o_pixel_format_q);
    chk("gamma", 12'h000, o_gamma_set_q);
    chk("test mode", 12'h000, o_test_mode_q);
    $display("Test reset done");
    ef = 3'h3;
    for (i = 0; i < 6; i = i + 1) begin
      p = 8'(48'hf2_05_fb_01_7a_07 >> (40 - 8 * i));
      host.send(1'b0, `PFGL_CMD_PIXEL_FORMAT_SET);
      host.send(1'b1, p);
      if (p[2:0] == 3'h2 || p[2:0] == 3'h3) ef = p[2:0];
      chk("format", {9'h000, ef}, o_pixel_format_q);
    end
    pixel_in(12'h0ff);
    checks = checks + 1;
    if (o_pixel_q === 12'h0ff) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED lut pixel expected translated seen %h", o_pixel_q);
    end
    host.send(1'b0, `PFGL_CMD_PIXEL_FORMAT_SET);
    host.send(1'b1, 8'h03);
    pixel_in(12'ha5c);
    chk("pixel", 12'ha5c, o_pixel_q);
    $display("Test format done");
    eg = 1'b0;
    for (i = 0; i < 5; i = i + 1) begin
      p = 8'(40'hfe_00_03_01_fe >> (32 - 8 * i));
      host.send(1'b0, `PFGL_CMD_GAMMA_SELECT);
      host.send(1'b1, p);
      if (p[1:0] == 2'h1 || p[1:0] == 2'h2) eg = p[1];
      chk("gamma", {11'h000, eg}, o_gamma_set_q);
    end
    host.send_table(`PFGL_CMD_GRAY_SET_ZERO, 8'h04);
    host.send_table(`PFGL_CMD_GRAY_SET_ONE, 8'h08);
    look(4'h1, 8'h0a);
    look(4'hf, 8'h7a);
    host.send(1'b0, `PFGL_CMD_GAMMA_SELECT);
    host.send(1'b1, 8'h01);
    look(4'h1, 8'h06);
    look(4'hf, 8'h3e);
    look(4'h0, 8'h00);
    reg_wr(4'h6, 8'h05);
    reg_wr(4'h1, 8'h02);
    reg_rd(4'h6, 8'h05);
    reg_rd(4'h4, 8'h16);
    reg_rd(4'h5, 8'h2a);
    reg_rd(4'h7, 8'h00);
    chk("format", 12'h003, o_pixel_format_q);
    $display("Test gray done");
    host.send(1'b0, `PFGL_CMD_GRAY_SET_ZERO);
    host.send(1'b1, 8'h03);
    host.send(1'b0, `PFGL_CMD_PIXEL_FORMAT_SET);
    host.send(1'b1, 8'h02);
    chk("format", 12'h002, o_pixel_format_q);
    look(4'h1, 8'h03);
    look(4'h2, 8'h0a);
    $display("Test abandon done");
    for (i = 0; i < 2; i = i + 1) begin
      host.send(1'b0, `PFGL_CMD_TEST_MODE_ENTRY);
      chk("test mode", 12'h001, o_test_mode_q);
      host.send(1'b0, `PFGL_CMD_PIXEL_FORMAT_SET);
      host.send(1'b1, 8'h03);
      chk("format", 12'h002, o_pixel_format_q);
      host.send(1'b0, i ? `PFGL_CMD_NO_OPERATION : `PFGL_CMD_NO_OPERATION_SECOND);
      chk("test mode", 12'h000, o_test_mode_q);
      chk("format", 12'h002, o_pixel_format_q);
    end
    host.send(1'b0, `PFGL_CMD_NO_OPERATION_SECOND);
    chk("test mode", 12'h000, o_test_mode_q);
    chk("format", 12'h002, o_pixel_format_q);
    reg_rd(`PFGL_REG_STATUS, 8'h00);
    $display("Test test mode done");
    for (i = 0; i < 4; i = i + 1) begin
      host.send(1'b0, 8'(32'hda_db_dc_b2 >> (24 - 8 * i)));
      reg_rd(`PFGL_REG_CHIP_TEST, 8'h01 << i);
    end
    chk("chip test", 12'h001, o_chip_test_q);
    chk("format", 12'h002, o_pixel_format_q);
    // Mid-run reset from non-default settings
    @(posedge i_clock);
    i_arst_n <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_arst_n <= 1'b1;
    @(posedge i_clock);
    #1 chk("format", 12'h003, o_pixel_format_q);
    chk("chip test", 12'h000, o_chip_test_q);
    chk("test mode", 12'h000, o_test_mode_q);
    $display("Test mid reset done");
    host.send(1'b0, `PFGL_CMD_PIXEL_FORMAT_SET);
    host.send(1'b1, 8'h02);
    chk("format", 12'h002, o_pixel_format_q);
    host.send(1'b0, `PFGL_CMD_GAMMA_SELECT);
    host.send(1'b1, 8'h02);
    host.send(1'b0, `PFGL_CMD_INITIAL_ESCAPE);
    chk("escape pulse", 12'h001, esc_seen);
    chk("format", 12'h003, o_pixel_format_q);
    chk("gamma", 12'h000, o_gamma_set_q);
    host.send(1'b1, 8'h02);
    chk("format", 12'h003, o_pixel_format_q);
    $display("Test escape done");
    final_report;
  end
endmodule // pfgl_cmd_decoder_bench
